// [rtl/harvest_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz reference clock
// Notes: Byte addresses as seen on the register request port
`ifndef HARVEST_CONSTS_SVH
`define HARVEST_CONSTS_SVH
// Register block addresses, reader side and wired side
`define A_START_CFG1 16'h0037
`define A_START_CFG1_W 16'h1037
`define A_START_HARV 16'h003D
`define A_START_HARV_W 16'h103D
`define A_STATUS 16'h00A0
`define A_STATUS_W 16'h10A0
`define A_SESS_CFG1 16'h00A1
`define A_SESS_CFG1_W 16'h10A1
`define A_SESS_HARV 16'h00A7
`define A_SESS_HARV_W 16'h10A7
// Harvest byte fields
`define B_ENABLE 0
`define B_VSEL 1
`define B_TRIGGER 3
`define B_ISEL 4
`define B_NO_PCHECK 6
`define B_LOAD_OK 7
// Configuration one fields
`define B_FIELD_MODE 0
`define B_ARB_FROM_START 1
`define B_ARB 2
// Status fields
`define B_SUPPLY_OK 0
`define B_OVERDUE 1
`define B_BOOT_DONE 7
// Reset values of the startup bytes and the session configuration byte
`define RST_START_HARV 8'h00
`define RST_START_CFG1 8'h00
`define RST_SESS_CFG1 8'h00
// Timing
`define CLK_HZ 20000000
`define DETECT_US 10
`define DETECT_CYC ((`DETECT_US * `CLK_HZ + 999999) / 1000000)
`define SETTLE_US 100
`define SETTLE_CYC ((`SETTLE_US * `CLK_HZ + 999999) / 1000000)
`define OVERDUE_MS 20
`define OVERDUE_CYC ((`OVERDUE_MS * `CLK_HZ) / 1000)
`endif

// [rtl/harvest_pkg.sv]
// Purpose: Types shared by the harvest enable sequencer
// Assumes: Nothing
// Notes: Binary state codes written out
package harvest_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_DETECT = 3'b001,
    ST_WAIT = 3'b010,
    ST_BOOT = 3'b011,
    ST_ON = 3'b100
  } seq_state_type;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_SESS_HARV = 3'b001,
    SEL_START_HARV = 3'b010,
    SEL_START_CFG1 = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_SESS_CFG1 = 3'b101
  } reg_sel_type;
endpackage

// [rtl/cycle_timer.sv]
// Purpose: Counts cycles while run is high, flags done at LIMIT
// Assumes: run low clears the count on the next enabled clock edge
// Notes: done is a level from a flop
`timescale 1ns/1ps
module cycle_timer #(
  parameter int LIMIT = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, low
  input wire logic clk_en, // Freeze when low
  input wire logic run, // Count while high
  output logic done // Limit reached
);
  localparam int W = $clog2(LIMIT + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } tmr_state_type;
  tmr_state_type q, d;

  // Saturating count, cleared when idle
  always_comb begin
    d = q;
    if (!run) begin
      d.cnt = '0;
    end else if (q.cnt != W'(LIMIT)) begin
      d.cnt = q.cnt + W'(1);
    end
    d.done = run && (d.cnt == W'(LIMIT));
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign done = q.done;
endmodule

// [rtl/rf_harvest_enable_sequencer.sv]
// Purpose: Decides when the regulated harvest output is switched on
// Assumes: Field, current and supply comparators arrive as raw pins
// Notes: Register port answers one cycle after each request
// Behaviour
// RULE1: Power check selectable by bit; acts only while field present
// RULE2: With check on, output enabled only when current beats reference
// RULE3: Check on and field weak: memory blocked, session registers remain
// RULE4: Load-sufficient bit 7 of session harvest byte shows enough energy
// RULE5: Session harvest byte at A7h or 10A7h, current session only
// RULE6: Startup harvest byte at 3Dh or 103Dh, used at power-up
// RULE7: Writing trigger bit 3 starts the current measurement
// RULE8: Writing enable and trigger together starts output and supply boot
// RULE9: Reader triggers, polls load bit, then writes the enable
// RULE10: Boot-done bit 7 of status A0h set once supply ramped
// RULE11: Reset from supply drop leaves session harvesting disabled
// RULE12: Reader acts if supply is not up within 20 ms
// RULE13: Supply toggling during boot restarts the supply boot
// RULE14: Supply below 1.62 V when running causes system reset
// RULE15: Startup enable: direct on if check off, else wait for field
// RULE16: Startup enable low makes the power check setting ineffective
// RULE17: Output follows voltage select and field mode selection
// RULE18: Field mode comes from startup configuration one at 37h
// RULE19: Arbiter-from-startup low takes arbitration from A1h session byte
// RULE20: Before boot starts, register access granted, memory refused
// RULE21: Field mode resets to low-field setting
`timescale 1ns/1ps
`include "harvest_consts.svh"
module rf_harvest_enable_sequencer
  import harvest_pkg::*;
#(
  parameter int OVERDUE_CYCLES = `OVERDUE_CYC,
  parameter int SETTLE_CYCLES = `SETTLE_CYC,
  parameter int DETECT_CYCLES = `DETECT_CYC
) (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic arst_n, // Async reset, low
  input wire logic clk_en, // Freeze when low
  input wire logic rf_field_present, // Field pin
  input wire logic current_above_ref, // Current comparator pin
  input wire logic supply_above_min, // Supply at least 1.62 V pin
  input wire logic reg_req, // Register request strobe
  input wire logic reg_write, // 1 write, 0 read
  input wire logic [15:0] reg_addr, // Block address
  input wire logic [7:0] reg_wdata, // Write byte
  output logic reg_ack, // Answer strobe
  output logic reg_refused, // Answer refused
  output logic [7:0] reg_rdata, // Read byte
  input wire logic mem_req, // Memory access request
  output logic mem_grant, // Memory access granted
  output logic mem_refused, // Memory access refused
  output logic regulator_enable, // Shunt regulator on
  output logic [1:0] harvest_voltage_select, // Output voltage code
  output logic [1:0] harvest_current_select, // Output current code
  output logic field_strength_mode, // 0 low field, 1 high
  output logic [1:0] arbitration_select, // Active arbitration mode
  output logic detect_active, // Measurement running
  output logic system_reset, // System reset pulse
  output logic supply_boot_done // Supply boot complete
);
  typedef struct packed {
    seq_state_type state;
    logic rf_s1;
    logic rf_s2;
    logic cur_s1;
    logic cur_s2;
    logic vcc_s1;
    logic vcc_s2;
    logic [7:0] start_harv;
    logic [7:0] start_cfg1;
    logic [7:0] sess_cfg1;
    logic sess_en;
    logic [1:0] sess_vsel;
    logic [1:0] sess_isel;
    logic load_ok;
    logic boot_done;
    logic overdue;
    logic reg_ack;
    logic reg_refused;
    logic [7:0] reg_rdata;
    logic mem_grant;
    logic mem_refused;
    logic reg_on;
    logic detect;
    logic [1:0] arb;
    logic sys_reset;
  } seq_type;
  seq_type q, d;

  logic detect_done;
  logic settle_done;
  logic overdue_done;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, both interfaces reach the same byte
  function automatic reg_sel_type decode(input logic [15:0] a);
    case (a)
      `A_SESS_HARV, `A_SESS_HARV_W: decode = SEL_SESS_HARV; // [RULE5]
      `A_START_HARV, `A_START_HARV_W: decode = SEL_START_HARV; // [RULE6]
      `A_START_CFG1, `A_START_CFG1_W: decode = SEL_START_CFG1;
      `A_STATUS, `A_STATUS_W: decode = SEL_STATUS;
      `A_SESS_CFG1, `A_SESS_CFG1_W: decode = SEL_SESS_CFG1;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Bytes that live in configuration memory
  function automatic logic is_memory(input reg_sel_type s);
    is_memory = (s == SEL_START_HARV) || (s == SEL_START_CFG1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Measurement, settle and overdue timers
  cycle_timer #(.LIMIT(DETECT_CYCLES)) u_detect (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(q.state == ST_DETECT),
    .done(detect_done)
  );
  cycle_timer #(.LIMIT(SETTLE_CYCLES)) u_settle (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(q.state == ST_BOOT && q.vcc_s2), // [RULE13]
    .done(settle_done)
  );
  cycle_timer #(.LIMIT(OVERDUE_CYCLES)) u_overdue (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .run(q.state == ST_BOOT),
    .done(overdue_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    reg_sel_type sel;
    logic rf;
    logic cur;
    logic vcc;
    logic trig_only;
    logic trig_en;
    logic start_en;
    logic no_check;
    logic blocked;
    sel = decode(reg_addr);
    d = q;
    // Two-stage synchronisers
    d.rf_s1 = rf_field_present;
    d.rf_s2 = q.rf_s1;
    d.cur_s1 = current_above_ref;
    d.cur_s2 = q.cur_s1;
    d.vcc_s1 = supply_above_min;
    d.vcc_s2 = q.vcc_s1;
    rf = q.rf_s2;
    cur = q.cur_s2;
    vcc = q.vcc_s2;
    start_en = q.start_harv[`B_ENABLE];
    // Check setting ignored unless startup enable is set
    no_check = q.start_harv[`B_NO_PCHECK] || !start_en; // [RULE16]
    blocked = !q.boot_done; // [RULE20]
    trig_only = 1'b0;
    trig_en = 1'b0;
    d.reg_ack = 1'b0;
    d.reg_refused = 1'b0;
    d.reg_rdata = 8'h00;
    d.mem_grant = 1'b0;
    d.mem_refused = 1'b0;
    d.sys_reset = 1'b0;

    // Memory requests only after supply boot
    if (mem_req) begin
      d.mem_grant = !blocked; // [RULE3]
      d.mem_refused = blocked; // [RULE3]
    end

    // Register access
    if (reg_req) begin
      d.reg_ack = 1'b1;
      if (sel == SEL_NONE || (is_memory(sel) && blocked)) begin
        d.reg_refused = 1'b1; // [RULE3]
      end else if (reg_write) begin
        case (sel)
          SEL_SESS_HARV: begin
            d.sess_vsel = reg_wdata[`B_VSEL +: 2];
            d.sess_isel = reg_wdata[`B_ISEL +: 2];
            if (reg_wdata[`B_TRIGGER] && reg_wdata[`B_ENABLE]) begin
              trig_en = 1'b1; // [RULE8]
            end else if (reg_wdata[`B_TRIGGER]) begin
              trig_only = 1'b1; // [RULE7]
            end
          end
          SEL_START_HARV: d.start_harv = reg_wdata;
          SEL_START_CFG1: d.start_cfg1 = reg_wdata;
          SEL_SESS_CFG1: d.sess_cfg1 = reg_wdata;
          default: d.reg_refused = 1'b1;
        endcase
      end else begin
        case (sel)
          SEL_SESS_HARV: begin
            d.reg_rdata[`B_ENABLE] = q.sess_en;
            d.reg_rdata[`B_VSEL +: 2] = q.sess_vsel;
            d.reg_rdata[`B_ISEL +: 2] = q.sess_isel;
            d.reg_rdata[`B_LOAD_OK] = q.load_ok; // [RULE4]
          end
          SEL_START_HARV: d.reg_rdata = q.start_harv;
          SEL_START_CFG1: d.reg_rdata = q.start_cfg1;
          SEL_STATUS: begin
            d.reg_rdata[`B_BOOT_DONE] = q.boot_done; // [RULE10]
            d.reg_rdata[`B_OVERDUE] = q.overdue;
            d.reg_rdata[`B_SUPPLY_OK] = vcc;
          end
          SEL_SESS_CFG1: d.reg_rdata = q.sess_cfg1;
          default: d.reg_refused = 1'b1;
        endcase
      end
    end

    // Sequencer
    case (q.state)
      ST_OFF: begin
        if (trig_en) begin
          d.sess_en = 1'b1;
          d.state = ST_BOOT; // [RULE8]
        end else if (trig_only) begin
          d.load_ok = 1'b0;
          d.state = ST_DETECT; // [RULE7]
        end else if (rf && start_en && no_check) begin
          d.state = ST_BOOT; // [RULE15]
        end else if (rf && start_en) begin
          d.state = ST_WAIT; // [RULE15]
        end
      end
      ST_DETECT: begin
        if (trig_en) begin
          d.sess_en = 1'b1;
          d.state = ST_BOOT;
        end else if (detect_done) begin
          // Result counts only with field present
          d.load_ok = rf && cur; // [RULE1]
          d.state = ST_OFF;
        end
      end
      ST_WAIT: begin
        if (trig_en) begin
          d.sess_en = 1'b1;
          d.state = ST_BOOT;
        end else if (rf && cur) begin
          d.state = ST_BOOT; // [RULE2]
        end
      end
      ST_BOOT: begin
        // Supply dip clears the settle count, boot starts over
        if (settle_done && vcc) begin
          d.boot_done = 1'b1; // [RULE10]
          d.state = ST_ON;
        end
        if (overdue_done) begin
          d.overdue = 1'b1;
        end
      end
      ST_ON: begin
        if (!vcc) begin
          d.sys_reset = 1'b1; // [RULE14]
          d.state = ST_OFF;
        end
      end
      default: d.state = ST_OFF;
    endcase

    // Supply loss after boot or field loss ends the session
    if (d.sys_reset || !rf) begin
      d.state = ST_OFF;
      d.sess_en = 1'b0; // [RULE11]
      d.load_ok = 1'b0;
      d.boot_done = 1'b0;
      d.overdue = 1'b0;
      d.sess_vsel = q.start_harv[`B_VSEL +: 2];
      d.sess_isel = q.start_harv[`B_ISEL +: 2];
    end

    // Registered outputs
    d.reg_on = (d.state == ST_BOOT) || (d.state == ST_ON); // [RULE17]
    d.detect = (d.state == ST_DETECT); // [RULE7]
    if (d.start_cfg1[`B_ARB_FROM_START]) begin
      d.arb = d.start_cfg1[`B_ARB +: 2];
    end else begin
      d.arb = d.sess_cfg1[`B_ARB +: 2]; // [RULE19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.state <= ST_OFF;
      q.start_harv <= `RST_START_HARV;
      q.start_cfg1 <= `RST_START_CFG1; // [RULE21]
      q.sess_cfg1 <= `RST_SESS_CFG1;
      q.sess_vsel <= 2'(`RST_START_HARV >> `B_VSEL);
      q.sess_isel <= 2'(`RST_START_HARV >> `B_ISEL);
    end else if (clk_en) begin
      q <= d;
    end
  end

  // Output drive
  assign reg_ack = q.reg_ack;
  assign reg_refused = q.reg_refused;
  assign reg_rdata = q.reg_rdata;
  assign mem_grant = q.mem_grant;
  assign mem_refused = q.mem_refused;
  assign regulator_enable = q.reg_on;
  assign harvest_voltage_select = q.sess_vsel; // [RULE17]
  assign harvest_current_select = q.sess_isel;
  assign field_strength_mode = q.start_cfg1[`B_FIELD_MODE]; // [RULE18]
  assign arbitration_select = q.arb;
  assign detect_active = q.detect;
  assign system_reset = q.sys_reset;
  assign supply_boot_done = q.boot_done;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !clk_en);
  a_mem_locked: assert property ( // [RULE3]
    mem_req && !q.boot_done |=> mem_refused && !mem_grant)
    else $error("memory granted before supply boot");
  a_load_bit_read: assert property ( // [RULE4]
    reg_req && !reg_write && decode(reg_addr) == SEL_SESS_HARV
    |=> reg_rdata[`B_LOAD_OK] == $past(q.load_ok) && !reg_refused)
    else $error("load bit not shown on read");
  a_trigger_start: assert property ( // [RULE7]
    q.state == ST_OFF && q.rf_s2 && reg_req && reg_write &&
    decode(reg_addr) == SEL_SESS_HARV && reg_wdata[`B_TRIGGER] &&
    !reg_wdata[`B_ENABLE] |=> detect_active)
    else $error("trigger did not start measurement");
  a_enable_boot: assert property ( // [RULE8]
    q.state == ST_OFF && q.rf_s2 && reg_req && reg_write &&
    decode(reg_addr) == SEL_SESS_HARV && reg_wdata[`B_TRIGGER] &&
    reg_wdata[`B_ENABLE] |=> regulator_enable && q.state == ST_BOOT)
    else $error("enable write did not start boot");
  a_wait_gate: assert property ( // [RULE2]
    q.state == ST_WAIT && !q.cur_s2 && !reg_req |=> !regulator_enable)
    else $error("output enabled below reference");
  a_boot_restart: assert property ( // [RULE13]
    q.state == ST_BOOT && !q.vcc_s2 && q.rf_s2
    |=> !supply_boot_done ##1 !supply_boot_done)
    else $error("boot finished across supply dip");
  a_low_supply_rst: assert property ( // [RULE14]
    q.state == ST_ON && !q.vcc_s2
    |=> system_reset && !regulator_enable ##1 !system_reset)
    else $error("no reset on supply loss");
  a_session_drop: assert property ( // [RULE11]
    system_reset |-> !q.sess_en && !supply_boot_done)
    else $error("session enable survived reset");
  a_startup_direct: assert property ( // [RULE15]
    q.state == ST_OFF && q.rf_s2 && q.start_harv[`B_ENABLE] &&
    q.start_harv[`B_NO_PCHECK] && !reg_req |=> regulator_enable)
    else $error("startup enable not direct");
  a_arb_source: assert property ( // [RULE19]
    !q.start_cfg1[`B_ARB_FROM_START]
    |-> arbitration_select == q.sess_cfg1[`B_ARB +: 2])
    else $error("arbitration not from session byte");
endmodule

// [sim/nfc_reader_model.sv]
// Purpose: Reader side model issuing register commands
// Assumes: One-cycle request strobe, answer one cycle later
// Notes: Idle address and data lines show the inverse of the last value
`timescale 1ns/1ps
module nfc_reader_model (
  input wire logic ref_clk, // Clock
  input wire logic reg_ack, // Answer strobe
  input wire logic reg_refused, // Answer refused
  input wire logic [7:0] reg_rdata, // Read byte
  output logic reg_req, // Request strobe
  output logic reg_write, // Write flag
  output logic [15:0] reg_addr, // Block address
  output logic [7:0] reg_wdata // Write byte
);
  // Quiet lines at time zero
  initial begin
    reg_req = 1'b0;
    reg_write = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // One command; lines held through the answer, then inverted
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [7:0] d, input int gap, output logic [1:0] st,
    output logic [7:0] rd);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    reg_req = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_req = 1'b0;
    st = {reg_ack, reg_refused};
    rd = reg_rdata;
    @(posedge ref_clk);
    #1;
    reg_write = ~w;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Polls one bit of a byte, bounded number of reads, uneven spacing
  task automatic poll(input logic [15:0] a, input int b, input int lim,
    output logic hit);
    logic [1:0] st;
    logic [7:0] rd;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      xfer(1'b0, a, 8'h00, i % 3, st, rd);
      hit = rd[b];
    end
  endtask

  // Trigger, wait for load, enable, then wait for boot done
  task automatic run_session(input logic [7:0] sel, input int lim,
    output logic load_hit, output logic boot_hit);
    logic [1:0] st;
    logic [7:0] rd;
    boot_hit = 1'b0;
    xfer(1'b1, 16'h00A7, 8'h08, 0, st, rd);
    poll(16'h00A7, 7, 8, load_hit);
    if (load_hit) begin
      xfer(1'b1, 16'h00A7, sel | 8'h09, 0, st, rd);
      poll(16'h00A0, 7, lim, boot_hit);
    end
  endtask
endmodule

// [sim/rf_harvest_enable_sequencer_bench.sv]
// Purpose: Self-checking bench of the harvest enable sequencer
// Assumes: Short timer parameters, pins settle after three edges
// Notes: Register traffic goes through the reader model
`timescale 1ns/1ps
module rf_harvest_enable_sequencer_bench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic rf_field_present = 1'b0;
  logic current_above_ref = 1'b0;
  logic supply_above_min = 1'b0;
  logic mem_req = 1'b0;
  logic reg_req, reg_write, reg_ack, reg_refused, mem_grant, mem_refused;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, sel;
  logic regulator_enable, field_strength_mode, detect_active;
  logic system_reset, supply_boot_done, load_hit, boot_hit;
  logic [1:0] harvest_voltage_select, harvest_current_select;
  logic [1:0] arbitration_select;
  logic [7:0] rst_pulses = 8'h00;
  logic [7:0] cfgs [2] = '{8'h0B, 8'h09};
  int err_count = 0;
  int total_checks = 0;
  integer seed, r;

  // Clock at 20 MHz
  always #25 ref_clk = ~ref_clk;

  // Counts reset pulses from the sequencer
  always @(posedge ref_clk) begin
    if (system_reset === 1'b1) begin
      rst_pulses <= rst_pulses + 8'h01;
    end
  end

  rf_harvest_enable_sequencer #(.OVERDUE_CYCLES(50), .SETTLE_CYCLES(8),
    .DETECT_CYCLES(4)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .clk_en(clk_en), .rf_field_present(rf_field_present),
    .current_above_ref(current_above_ref),
    .supply_above_min(supply_above_min), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_refused(reg_refused), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_grant(mem_grant), .mem_refused(mem_refused),
    .regulator_enable(regulator_enable),
    .harvest_voltage_select(harvest_voltage_select),
    .harvest_current_select(harvest_current_select),
    .field_strength_mode(field_strength_mode),
    .arbitration_select(arbitration_select),
    .detect_active(detect_active), .system_reset(system_reset),
    .supply_boot_done(supply_boot_done));

  nfc_reader_model u_reader (.ref_clk(ref_clk), .reg_ack(reg_ack),
    .reg_refused(reg_refused), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pins(input logic f, input logic c, input logic s);
    rf_field_present = f;
    current_above_ref = c;
    supply_above_min = s;
  endtask

  task automatic rw(input logic w, input logic [15:0] a,
    input logic [7:0] d, input logic [1:0] ex, output logic [7:0] q);
    logic [1:0] st;
    u_reader.xfer(w, a, d, 0, st, q);
    check({6'h00, st}, {6'h00, ex});
  endtask

  task automatic mem(input logic [1:0] ex);
    @(posedge ref_clk);
    #1;
    mem_req = 1'b1;
    @(posedge ref_clk);
    #1;
    mem_req = 1'b0;
    check({6'h00, mem_grant, mem_refused}, {6'h00, ex});
  endtask

  // Expected session harvest byte; trigger reads back 0
  function automatic logic [7:0] harv_exp(input logic en,
    input logic [7:0] s, input logic load);
    return {load, 1'b0, s[5:4], 1'b0, s[2:1], en};
  endfunction

  // Arbitration from startup byte only when its bit1 is set
  function automatic logic [7:0] arb_exp(input logic [7:0] st,
    input logic [7:0] ss);
    return {6'h00, st[1] ? st[3:2] : ss[3:2]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(4000 * 50);
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    seed = 94;
    cyc(10);
    arst_n = 1'b1;
    chk1(regulator_enable, 1'b0);
    chk1(field_strength_mode, 1'b0);
    rw(1'b0, 16'h0037, 8'h00, 2'b11, rd);
    rw(1'b0, 16'h103D, 8'h00, 2'b11, rd);
    rw(1'b1, 16'h00A0, 8'hFF, 2'b11, rd);
    mem(2'b01);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      rw(r[8], 16'h00B0 + {10'h000, r[5:0]}, r[7:0], 2'b11, rd);
    end
    // Weak current: measurement runs, load stays low
    pins(1'b1, 1'b0, 1'b0);
    cyc(4);
    rw(1'b1, 16'h00A7, 8'h08, 2'b10, rd);
    chk1(detect_active, 1'b1);
    chk1(regulator_enable, 1'b0);
    // Frozen clock enable holds the measurement
    clk_en = 1'b0;
    cyc(8);
    chk1(detect_active, 1'b1);
    clk_en = 1'b1;
    cyc(8);
    chk1(detect_active, 1'b0);
    rw(1'b0, 16'h00A7, 8'h00, 2'b10, rd);
    check(rd, harv_exp(1'b0, 8'h00, 1'b0));
    // Session enable with a supply glitch during boot
    r = $random(seed);
    sel = {2'b00, r[1:0], 1'b0, r[3:2], 1'b0};
    current_above_ref = 1'b1;
    fork
      u_reader.run_session(sel, 12, load_hit, boot_hit);
      begin
        wait (regulator_enable === 1'b1);
        cyc(1);
        supply_above_min = 1'b1;
        cyc(4);
        supply_above_min = 1'b0;
        cyc(2);
        chk1(supply_boot_done, 1'b0);
        supply_above_min = 1'b1;
      end
    join
    chk1(load_hit, 1'b1);
    chk1(boot_hit, 1'b1);
    chk1(regulator_enable, 1'b1);
    check({4'h0, harvest_current_select, harvest_voltage_select},
      {4'h0, sel[5:4], sel[2:1]});
    mem(2'b10);
    rw(1'b0, 16'h10A7, 8'h00, 2'b10, rd);
    check(rd, harv_exp(1'b1, sel, 1'b1));
    // Field mode and arbitration source
    rw(1'b1, 16'h00A1, 8'h04, 2'b10, rd);
    rw(1'b0, 16'h00A1, 8'h00, 2'b10, rd);
    check(rd, 8'h04);
    for (int k = 0; k < 2; k++) begin
      rw(1'b1, 16'h1037, cfgs[k], 2'b10, rd);
      chk1(field_strength_mode, 1'b1);
      check({6'h00, arbitration_select}, arb_exp(cfgs[k], 8'h04));
    end
    rw(1'b0, 16'h0037, 8'h00, 2'b10, rd);
    check(rd, 8'h09);
    rw(1'b1, 16'h103D, 8'h40, 2'b10, rd);
    rw(1'b0, 16'h003D, 8'h00, 2'b10, rd);
    check(rd, 8'h40);
    // Supply loss after boot
    supply_above_min = 1'b0;
    cyc(5);
    check(rst_pulses, 8'h01);
    chk1(supply_boot_done, 1'b0);
    cyc(8);
    chk1(regulator_enable, 1'b0);
    rw(1'b0, 16'h00A7, 8'h00, 2'b10, rd);
    chk1(rd[0], 1'b0);
    mem(2'b01);
    // Startup enable with check off, then on
    supply_above_min = 1'b1;
    u_reader.run_session(8'h00, 12, load_hit, boot_hit);
    chk1(boot_hit, 1'b1);
    rw(1'b1, 16'h003D, 8'h41, 2'b10, rd);
    pins(1'b0, 1'b0, 1'b1);
    cyc(4);
    pins(1'b1, 1'b0, 1'b1);
    cyc(5);
    chk1(regulator_enable, 1'b1);
    cyc(12);
    chk1(supply_boot_done, 1'b1);
    rw(1'b1, 16'h003D, 8'h01, 2'b10, rd);
    pins(1'b0, 1'b0, 1'b0);
    cyc(4);
    pins(1'b1, 1'b0, 1'b0);
    cyc(8);
    chk1(regulator_enable, 1'b0);
    mem(2'b01);
    rw(1'b0, 16'h00A7, 8'h00, 2'b10, rd);
    rw(1'b0, 16'h003D, 8'h00, 2'b11, rd);
    current_above_ref = 1'b1;
    cyc(5);
    chk1(regulator_enable, 1'b1);
    cyc(55);
    rw(1'b0, 16'h00A0, 8'h00, 2'b10, rd);
    check(rd & 8'h82, 8'h02);
    // Second reset brings the field mode back to low field
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    chk1(field_strength_mode, 1'b0);
    chk1(supply_boot_done, 1'b0);
    give_verdict();
  end
endmodule
